//--- strap_regs_pkg.sv
/*
  constants for the strap status register bank: word indices, field
  positions, reset values, packing of the captured strap vector.
  assumes a 32-bit classic wishbone bus with byte addressing.
*/
package strap_regs_pkg;

  // bus geometry
  localparam int ADR_W = 14;
  localparam int IDX_W = 12;
  localparam int DAT_W = 32;
  localparam int REG_W = 16;

  // word indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STRAP_ONE = 12'h45d;
  localparam logic [IDX_W-1:0] IDX_STRAP_TWO = 12'h45e;

  localparam logic [REG_W-1:0] RST_STRAP_ONE = 16'h0000;
  localparam logic [REG_W-1:0] RST_STRAP_TWO = 16'h0000;

  // strap_status_one field positions
  localparam int BIT_TX_DELAY = 15;
  localparam int BIT_RX_DELAY = 14;
  localparam int BIT_SERIAL = 13;
  localparam int BIT_PARALLEL = 12;
  localparam int RSV_ONE_MSB = 11;
  localparam int RSV_ONE_LSB = 9;
  localparam int MODE_MSB = 8;
  localparam int MODE_LSB = 6;
  localparam int BIT_ROLE = 5;
  localparam int ADDR_MSB = 4;
  localparam int ADDR_LSB = 0;

  // strap_status_two field positions
  localparam int BIT_MANAGED = 0;

  // mac mode encodings
  localparam logic [2:0] MAC_MODE_ALIGN = 3'h4;
  localparam logic [2:0] MAC_MODE_TX = 3'h5;
  localparam logic [2:0] MAC_MODE_TXRX = 3'h6;

  // packing of the strap vector carried between modules
  localparam int STRAP_W = 14;
  localparam int V_ADDR_LSB = 0;
  localparam int V_ROLE = 5;
  localparam int V_MODE_LSB = 6;
  localparam int V_PAR = 9;
  localparam int V_SER = 10;
  localparam int V_RX = 11;
  localparam int V_TX = 12;
  localparam int V_MANAGED = 13;

  // cycles after reset release before straps are latched
  localparam int SETTLE_CYCLES = 4;
  localparam int SYNC_STAGES = 2;

  // the only management addresses a strap can select
  function automatic logic mgmt_addr_legal(input logic [4:0] a);
    case (a)
      5'h00, 5'h04, 5'h05, 5'h08, 5'h0a, 5'h0c, 5'h0d, 5'h0e, 5'h0f:
        mgmt_addr_legal = 1'b1;
      default:
        mgmt_addr_legal = 1'b0;
    endcase
  endfunction

endpackage

//--- strap_sync.sv
/*
  two-flop synchroniser for a vector of strap pins.
  assumes each bit is a slow level; bits are not mutually coherent,
  which is fine because straps are latched only after they settle.
*/
`timescale 1ns/1ps
module strap_sync #(
  parameter int W = 14
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins and synchronised copy
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  import strap_regs_pkg::*;

  generate
    if (W < 1)
    begin : g_bad_w
      $error("strap_sync: W must be at least 1");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= pin[i];
          sync_q <= meta_q;
        end
      end
      assign level[i] = sync_q;
    end
  endgenerate
endmodule

//--- strap_capture.sv
/*
  latches the synchronised strap vector once, a fixed number of cycles
  after reset release, and holds it until the next reset.
  assumes the input comes from strap_sync on the same clock.
*/
`timescale 1ns/1ps
module strap_capture #(
  parameter int W = 14,
  parameter int SETTLE = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // synchronised straps in, frozen copy out
  input wire logic [W-1:0] level,
  output logic [W-1:0] captured,
  output logic valid
);
  import strap_regs_pkg::*;

  generate
    // the latch edge must come after the last sync stage has filled
    if (SETTLE <= SYNC_STAGES || SETTLE > 255 || W < 1)
    begin : g_bad_param
      $error("strap_capture: SETTLE must be 3..255 and W at least 1");
    end
  endgenerate

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic valid_q;
  logic [W-1:0] cap_q;
  logic settled;

  // wait out the synchroniser so no stale zero is latched
  assign settled = (count_q == 8'(SETTLE - 1));
  assign count_d = valid_q ? count_q : count_q + 8'h01;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= 8'h00;
      valid_q <= 1'b0;
      cap_q <= '0;
    end
    else
    begin
      count_q <= count_d;
      if (settled && !valid_q)
      begin
        valid_q <= 1'b1;
        cap_q <= level;
      end
    end
  end

  assign captured = cap_q;
  assign valid = valid_q;
endmodule

//--- strap_status_regs.sv
/*
  strap status register bank behind a classic wishbone slave.
  straps are sampled once after reset and reported read-only.
  assumes strap pins are static levels while rst is released and for
  a few cycles after; later changes of the pins are ignored.
*/
// What this block does
// - report strap-selected modes latched after reset, read-only to software
// - later mode overrides elsewhere never change the reported strap values
// - bit 15 of strap_status_one shows strapped transmit clock delay
// - bit 14 of strap_status_one shows strapped receive clock delay
// - bit 13 of strap_status_one shows serial mac interface strapped
// - bit 12 of strap_status_one shows parallel mac interface strapped
// - bits 8 to 6 give strapped mac mode; 4 align, 5 tx, 6 both
// - bits 4 to 0 give strapped management address from the legal set
// - strap_status_two bit 0 is managed mode; bits 15 to 1 read zero
`timescale 1ns/1ps
module strap_status_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [strap_regs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [strap_regs_pkg::DAT_W-1:0] wb_dat_i,
  output logic [strap_regs_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // strap pins
  input wire logic strap_tx_delay,
  input wire logic strap_rx_delay,
  input wire logic strap_serial_mac,
  input wire logic strap_parallel_mac,
  input wire logic [2:0] strap_mac_mode,
  input wire logic link_role_strap,
  input wire logic [4:0] mgmt_address_strap,
  input wire logic strap_managed,
  // status
  output logic straps_valid
);
  import strap_regs_pkg::*;

  logic [STRAP_W-1:0] strap_pins;
  logic [STRAP_W-1:0] strap_level;
  logic [STRAP_W-1:0] strap_cap;
  logic cap_valid;

  assign strap_pins[V_ADDR_LSB +: 5] = mgmt_address_strap;
  assign strap_pins[V_ROLE] = link_role_strap;
  assign strap_pins[V_MODE_LSB +: 3] = strap_mac_mode;
  assign strap_pins[V_PAR] = strap_parallel_mac;
  assign strap_pins[V_SER] = strap_serial_mac;
  assign strap_pins[V_RX] = strap_rx_delay;
  assign strap_pins[V_TX] = strap_tx_delay;
  assign strap_pins[V_MANAGED] = strap_managed;

  strap_sync #(
    .W(STRAP_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin(strap_pins),
    .level(strap_level)
  );

  strap_capture #(
    .W(STRAP_W),
    .SETTLE(SETTLE_CYCLES)
  ) u_capture (
    .core_clk(core_clk),
    .rst(rst),
    .level(strap_level),
    .captured(strap_cap),
    .valid(cap_valid)
  );

  // field views of the frozen straps
  wire logic [4:0] cap_addr = strap_cap[V_ADDR_LSB +: 5];
  wire logic [2:0] cap_mode = strap_cap[V_MODE_LSB +: 3];
  wire logic cap_role = strap_cap[V_ROLE];
  wire logic cap_par = strap_cap[V_PAR];
  wire logic cap_ser = strap_cap[V_SER];
  wire logic cap_rx = strap_cap[V_RX];
  wire logic cap_tx = strap_cap[V_TX];
  wire logic cap_managed = strap_cap[V_MANAGED];

  // an address outside the strappable set cannot come from the
  // resistor ladder; report zero rather than an impossible value
  wire logic addr_ok = mgmt_addr_legal(cap_addr);
  wire logic [4:0] rep_addr = addr_ok ? cap_addr : 5'h00;

  // register images; zero until the straps are latched
  logic [REG_W-1:0] img_one;
  logic [REG_W-1:0] img_two;

  always_comb
  begin
    img_one = RST_STRAP_ONE;
    img_two = RST_STRAP_TWO;
    if (cap_valid)
    begin
      img_one[BIT_TX_DELAY] = cap_tx;
      img_one[BIT_RX_DELAY] = cap_rx;
      img_one[BIT_SERIAL] = cap_ser;
      img_one[BIT_PARALLEL] = cap_par;
      img_one[MODE_MSB:MODE_LSB] = cap_mode;
      img_one[BIT_ROLE] = cap_role;
      img_one[ADDR_MSB:ADDR_LSB] = rep_addr;
      img_two[BIT_MANAGED] = cap_managed;
    end
  end

  // bus decode
  wire logic [IDX_W-1:0] req_idx = wb_adr_i[ADR_W-1:2];
  wire logic hit_one = (req_idx == IDX_STRAP_ONE);
  wire logic hit_two = (req_idx == IDX_STRAP_TWO);
  wire logic req_new = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic req_hit = req_new && (hit_one || hit_two);
  wire logic req_miss = req_new && !(hit_one || hit_two);
  // writes are acknowledged but change nothing
  wire logic [REG_W-1:0] sel_img =
    (hit_one && !wb_we_i) ? img_one :
    (hit_two && !wb_we_i) ? img_two : '0;

  logic ack_q;
  logic err_q;
  logic [DAT_W-1:0] dat_q;
  logic [DAT_W-1:0] dat_d;
  logic valid_q;

  assign dat_d = req_hit ? {16'h0000, sel_img} : '0;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      ack_q <= req_hit;
      err_q <= req_miss;
      dat_q <= dat_d;
      valid_q <= cap_valid;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = dat_q;
  assign straps_valid = valid_q;

  // checking
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  wire logic rd_one = req_hit && hit_one && !wb_we_i && cap_valid;
  wire logic rd_two = req_hit && hit_two && !wb_we_i && cap_valid;
  wire logic wr_any = req_hit && wb_we_i;

  // cycles since reset release, saturating; feeds the checks only
  logic [7:0] age_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      age_q <= 8'h00;
    else if (age_q != 8'hff)
      age_q <= age_q + 8'h01;
  end

  a_frozen_after_latch: assert property (
    cap_valid |=> cap_valid && $stable(strap_cap))
    else $error("latched straps changed after capture");

  a_write_no_change: assert property (
    wr_any && cap_valid |=> wb_ack_o && wb_dat_o == '0
      ##1 $stable(strap_cap))
    else $error("write returned data or disturbed the straps");

  a_tx_delay_bit: assert property (
    rd_one |=> wb_ack_o && wb_dat_o[BIT_TX_DELAY] == $past(cap_tx))
    else $error("transmit delay bit mismatch");

  a_rx_delay_bit: assert property (
    rd_one |=> wb_ack_o && wb_dat_o[BIT_RX_DELAY] == $past(cap_rx))
    else $error("receive delay bit mismatch");

  a_mac_select_bits: assert property (
    rd_one |=> wb_dat_o[BIT_SERIAL] == $past(cap_ser)
      && wb_dat_o[BIT_PARALLEL] == $past(cap_par))
    else $error("mac interface select bits mismatch");

  a_mac_mode_field: assert property (
    rd_one |=> wb_dat_o[MODE_MSB:MODE_LSB] == $past(cap_mode))
    else $error("mac mode field mismatch");

  a_mgmt_addr_field: assert property (
    rd_one |=> mgmt_addr_legal(wb_dat_o[ADDR_MSB:ADDR_LSB])
      && (!$past(addr_ok)
        || wb_dat_o[ADDR_MSB:ADDR_LSB] == $past(cap_addr)))
    else $error("management address field wrong or illegal");

  a_managed_bit: assert property (
    rd_two |=> wb_dat_o[BIT_MANAGED] == $past(cap_managed)
      && wb_dat_o[DAT_W-1:1] == '0)
    else $error("managed bit wrong or upper bits set");

  a_reserved_role: assert property (
    rd_one |=> wb_dat_o[RSV_ONE_MSB:RSV_ONE_LSB] == 3'h0
      && wb_dat_o[BIT_ROLE] == $past(cap_role)
      && wb_dat_o[DAT_W-1:REG_W] == '0)
    else $error("reserved bits set or link role wrong");

  a_ack_single_pulse: assert property (
    req_new |=> (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o && !wb_err_o)
    else $error("answer not a single one-cycle pulse");

  a_settle_timing: assert property (
    $fell(rst) |-> !cap_valid [*4] ##1 cap_valid)
    else $error("straps not latched at the settle count");

  // answer shape on the bus
  a_err_on_miss: assert property (
    req_miss
      |=> wb_err_o && !wb_ack_o && wb_dat_o == '0)
    else $error("unmapped access not answered with an error");

  a_read_acked: assert property (
    req_hit && !wb_we_i
      |=> wb_ack_o && !wb_err_o)
    else $error("register read not acknowledged");

  a_write_acked: assert property (
    wr_any
      |=> wb_ack_o && !wb_err_o && wb_dat_o == '0)
    else $error("write not acknowledged with zero data");

  a_idle_quiet: assert property (
    !req_new
      |=> !wb_ack_o && !wb_err_o && wb_dat_o == '0)
    else $error("answer without a request");

  a_answer_one_cycle: assert property (
    wb_ack_o || wb_err_o
      |=> !wb_ack_o && !wb_err_o)
    else $error("answer stood longer than one cycle");

  a_ack_err_exclusive: assert property (
    !(wb_ack_o && wb_err_o))
    else $error("acknowledge and error together");

  a_data_only_ack: assert property (
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside an acknowledge");

  a_upper_half_zero: assert property (
    wb_dat_o[DAT_W-1:REG_W] == '0)
    else $error("upper half of the bus word not zero");

  // latch timing and contents
  a_zero_before_latch: assert property (
    req_hit && !wb_we_i && !cap_valid
      |=> wb_ack_o && wb_dat_o == '0)
    else $error("read before the latch returned nonzero data");

  // sync stages and the latch edge put the pins three edges back
  a_latch_value: assert property (
    $rose(cap_valid)
      |-> strap_cap == $past(strap_pins, 3))
    else $error("latched straps differ from the settled pins");

  a_latch_age: assert property (
    cap_valid == (age_q >= 8'(SETTLE_CYCLES)))
    else $error("straps latched at the wrong cycle");

  a_valid_follows_cap: assert property (
    straps_valid == $past(cap_valid))
    else $error("straps_valid does not follow the latch");

  a_valid_sticky: assert property (
    straps_valid |=> straps_valid)
    else $error("straps_valid fell without a reset");

  a_illegal_addr_zero: assert property (
    rd_one && !addr_ok
      |=> wb_dat_o[ADDR_MSB:ADDR_LSB] == 5'h00)
    else $error("impossible management address not read as zero");

  c_read_one: cover property (rd_one ##1 wb_ack_o);
  c_read_two: cover property (rd_two ##1 wb_ack_o);
  c_write_ignored: cover property (wr_any ##1 wb_ack_o);
  c_unmapped: cover property (req_miss ##1 wb_err_o);
  c_before_latch: cover property (
    req_hit && !wb_we_i && !cap_valid ##1 wb_ack_o);
endmodule

//--- testbench.sv
/*
  self-checking bench for the strap status register bank: random
  straps, reset, reads, ignored writes, pin changes, unmapped access.
  assumes strap_regs_pkg and strap_status_regs compiled before it.
*/
`timescale 1ns/1ps
module testbench;
  import strap_regs_pkg::*;
  logic core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [DAT_W-1:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, wb_err_o, straps_valid;
  // packed pins: tx rx ser par mode[6:4] role addr[12:8] managed
  logic [13:0] pins;
  int failures, compares;
  logic [4:0] legal [9] = '{5'h00, 5'h04, 5'h05, 5'h08, 5'h0a, 5'h0c,
    5'h0d, 5'h0e, 5'h0f};

  strap_status_regs dut (
    .core_clk(core_clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o),
    .strap_tx_delay(pins[0]),
    .strap_rx_delay(pins[1]),
    .strap_serial_mac(pins[2]),
    .strap_parallel_mac(pins[3]),
    .strap_mac_mode(pins[6:4]),
    .link_role_strap(pins[7]),
    .mgmt_address_strap(pins[12:8]),
    .strap_managed(pins[13]),
    .straps_valid(straps_valid)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one classic cycle; holds the request until ack or err is sampled;
  // a slave that never answers is left to the watchdog
  task bus(input logic we, input logic [11:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic [1:0] resp);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= wd;
    wb_sel_i <= 4'($urandom);
    do
    begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    resp = {wb_ack_o, wb_err_o};
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // expected image of the first strap register from the pins
  function automatic logic [31:0] img1(input logic [13:0] p);
    logic ok;
    ok = 1'b0;
    foreach (legal[i])
      if (legal[i] == p[12:8])
        ok = 1'b1;
    return {16'h0, p[0], p[1], p[2], p[3], 3'h0, p[6:4], p[7],
      ok ? p[12:8] : 5'h00};
  endfunction

  initial
  begin
    repeat (30000) @(posedge core_clk);
    failures++;
    give_verdict;
  end

  initial
  begin
    logic [31:0] rd;
    logic [1:0] resp;
    logic [13:0] p;
    int v;
    rst = 1'b1;
    pins = 14'h0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = 4'h0;
    wb_dat_i = '0;
    v = $urandom(32'hbcfc);
    for (int r = 0; r < 12; r++)
    begin
      p = 14'($urandom);
      // every legal address once, then an illegal one
      if (r < 9)
        p[12:8] = legal[r];
      if (r == 9)
        p[12:8] = 5'h01;
      // the three documented mode codes first
      if (r < 3)
        p[6:4] = 3'(r + 4);
      pins <= p;
      rst <= 1'b1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      // a read before the latch sees the reset image
      bus(1'b0, IDX_STRAP_ONE, 32'h0, rd, resp);
      check(rd, {16'h0, RST_STRAP_ONE});
      check({31'h0, straps_valid}, 32'h0);
      v = 0;
      while (straps_valid !== 1'b1 && v < 20)
      begin
        @(posedge core_clk);
        v++;
      end
      check({31'h0, straps_valid}, 32'h1);
      for (int k = 0; k < 2; k++)
      begin
        bus(1'b0, IDX_STRAP_ONE, 32'h0, rd, resp);
        check(rd, img1(p));
        check({30'h0, resp}, 32'h2);
        bus(1'b0, IDX_STRAP_TWO, 32'h0, rd, resp);
        check(rd, {31'h0, p[13]});
        // pins move and software writes; neither may show
        pins <= ~p;
        bus(1'b1, IDX_STRAP_ONE, $urandom, rd, resp);
        check(rd, 32'h0);
        check({30'h0, resp}, 32'h2);
        bus(1'b1, IDX_STRAP_TWO, $urandom, rd, resp);
        check(rd, 32'h0);
        check({30'h0, resp}, 32'h2);
        repeat (8) @(posedge core_clk);
      end
      bus(1'b0, (r % 2) ? 12'h45c : 12'(12'h45f + r), 32'h0, rd, resp);
      check(rd, 32'h0);
      check({30'h0, resp}, 32'h1);
    end
    give_verdict;
  end
endmodule
